// *** ftr_checker.sv ***
// Purpose: port checks of the fault reporter
// Assumes: one pclk domain, undervoltage mask left unmasked
// Notes:   sees only top-level ports
`include "ftr_map.vh"
`default_nettype none
module ftr_checker
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // events and pins
  input wire logic        ev_pll_clock_error,
  input wire logic        ev_regulator_overload,
  input wire logic        ev_regulator_undervoltage,
  input wire logic        hw_shutdown_n,
  input wire logic        status_sdata_oe,
  input wire logic        interrupt_request_n_out,
  input wire logic        interrupt_request_n_oe,
  input wire logic [4:0]  input_pulldown_enable,
  input wire logic        fault_shutdown
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_on_event_a: assert property (ev_regulator_undervoltage |=> interrupt_request_n_oe)
    else $error("irq missing after event");
  irq_pin_low_a: assert property (interrupt_request_n_oe |-> !interrupt_request_n_out)
    else $error("irq pin not driven low");
  pd_off_sd_a: assert property (!hw_shutdown_n [*4] |-> input_pulldown_enable == 5'h00)
    else $error("pull-down on in shutdown");
  slot_off_sd_a: assert property (!hw_shutdown_n [*4] |-> !status_sdata_oe)
    else $error("status slot driven in shutdown");
  fault_set_a: assert property ((ev_pll_clock_error || ev_regulator_overload) && hw_shutdown_n
    |-> ##[1:3] fault_shutdown) else $error("fault shutdown missing");
  fault_hold_a: assert property (hw_shutdown_n [*4] ##0 fault_shutdown |=> fault_shutdown)
    else $error("fault shutdown dropped");
  unmapped_read_a: assert property (psel && penable && !pwrite && paddr > 12'h010
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped access refused");

  cover property ($rose(interrupt_request_n_oe));
  cover property ($rose(status_sdata_oe));
  cover property (psel && penable && pslverr);
endmodule // ftr_checker

bind ftr_fault_reporter ftr_checker ftr_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .ev_pll_clock_error, .ev_regulator_overload,
  .ev_regulator_undervoltage, .hw_shutdown_n, .status_sdata_oe, .interrupt_request_n_out,
  .interrupt_request_n_oe, .input_pulldown_enable, .fault_shutdown);
`default_nettype wire

// *** ftr_fault_reporter.v ***
// Purpose: fault flags, interrupt masking and status slot of a mono amplifier
// Assumes: event inputs come from core logic on pclk; link and shutdown pins do not
// Notes:   latched flags clear on read or on write of one; a new event wins
//
// Chosen here: the APB slave port and the address map.
`include "ftr_map.vh"
`default_nettype none

module ftr_fault_reporter
#(
  parameter SLOT_BITS = `FTR_SLOT_BITS
)
(
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // fault events from core, one-cycle pulses
  input  wire        ev_bad_ratio_or_rate,
  input  wire        ev_frame_rate_changed,
  input  wire        ev_clock_ratio_changed,
  input  wire        ev_pll_clock_error,
  input  wire        ev_regulator_overvoltage,
  input  wire        ev_regulator_undervoltage,
  input  wire        ev_regulator_overload,
  input  wire        ev_brownout_powerdown,
  input  wire        ev_load_diag_complete,
  input  wire        ev_load_open,
  input  wire        ev_load_short,
  // live conditions from core, levels
  input  wire        cond_supply_below_inflection,
  input  wire        cond_limiter_active,
  input  wire        cond_limiter_max_attenuation,
  input  wire        cond_thermal_threshold_one,
  input  wire        cond_thermal_threshold_two,
  // operating state from core, levels
  input  wire        core_powered_up,
  input  wire        core_sw_shutdown,
  input  wire        core_shutdown_transient,
  input  wire        low_voltage_supply_rail_active,
  input  wire        noise_gate_active,
  input  wire        limiter_attenuating,
  input  wire        inter_chip_limiter_alignment_attenuating,
  input  wire        brownout_prevention_attenuating,
  input  wire        over_temperature,
  input  wire        over_current,
  input  wire        power_stage_supply_undervoltage,
  // pins
  input  wire        hw_shutdown_n,
  input  wire        serial_bit_clock,
  input  wire        frame_sync,
  output wire        status_sdata_out,
  output wire        status_sdata_oe,
  output reg         interrupt_request_n_out,
  output reg         interrupt_request_n_oe,
  output reg  [4:0]  input_pulldown_enable,
  output reg         fault_shutdown
);

  // register file
  reg [31:0]              ctrl_reg;
  reg [`FTR_LIVE_W-1:0]   live_reg;
  reg [`FTR_FLAG_W-1:0]   latched_reg;
  reg [`FTR_FLAG_W-1:0]   latched_next;
  reg [`FTR_FLAG_W-1:0]   mask_reg;
  reg [`FTR_FLAG_W-1:0]   rd_clear_reg;

  // synchronisers
  reg [1:0]               sd_sync_reg;
  reg [1:0]               bclk_sync_reg;
  reg [1:0]               fs_sync_reg;
  reg                     bclk_prev_reg;

  wire                    hw_sd;
  wire                    shut;
  wire                    bclk_rise;
  wire                    bclk_fall;
  wire                    setup;
  wire                    access;
  wire                    wr_access;
  wire                    rd_latched;
  wire [`FTR_FLAG_W-1:0]  set_vec;
  wire [`FTR_FLAG_W-1:0]  w1c_vec;
  wire [`FTR_LIVE_W-1:0]  live_next;
  wire [7:0]              status_word;
  wire                    tx_allowed;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `FTR_OFS_CTRL) || (a == `FTR_OFS_LIVE) ||
               (a == `FTR_OFS_LATCHED) || (a == `FTR_OFS_MASK) ||
               (a == `FTR_OFS_STATE);
    end
  endfunction

  assign hw_sd     = ~sd_sync_reg[1];
  assign shut      = hw_sd | core_sw_shutdown | fault_shutdown;
  assign bclk_rise = bclk_sync_reg[1] & ~bclk_prev_reg;
  assign bclk_fall = ~bclk_sync_reg[1] & bclk_prev_reg;
  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign wr_access = access & pwrite & mapped(paddr);
  assign rd_latched = access & ~pwrite & (paddr == `FTR_OFS_LATCHED);

  // live flags follow their conditions only while the device runs
  assign live_next = shut ? {`FTR_LIVE_W{1'b0}} :
                     {cond_thermal_threshold_two, cond_thermal_threshold_one,
                      cond_limiter_max_attenuation, cond_limiter_active,
                      cond_supply_below_inflection};

  // every event or live condition that raises a latched bit
  assign set_vec = {ev_load_short,
                    ev_load_open,
                    ev_load_diag_complete,
                    ev_brownout_powerdown,
                    live_next[4],
                    live_next[3],
                    ev_regulator_overload,
                    ev_regulator_undervoltage,
                    ev_regulator_overvoltage,
                    ev_pll_clock_error,
                    live_next[2],
                    live_next[1],
                    live_next[0],
                    ev_clock_ratio_changed,
                    ev_frame_rate_changed,
                    ev_bad_ratio_or_rate};

  assign w1c_vec = (wr_access && paddr == `FTR_OFS_LATCHED) ?
                   pwdata[`FTR_FLAG_W-1:0] : {`FTR_FLAG_W{1'b0}};

  always @*
  begin
    latched_next = latched_reg;
    if (rd_latched)
    begin
      latched_next = latched_next & ~rd_clear_reg;
    end
    latched_next = (latched_next & ~w1c_vec) | set_vec;
  end

  // status word as the host sees it in its slot
  assign status_word = {power_stage_supply_undervoltage & core_shutdown_transient,
                        over_current & core_shutdown_transient,
                        over_temperature & core_shutdown_transient,
                        brownout_prevention_attenuating,
                        limiter_attenuating | inter_chip_limiter_alignment_attenuating,
                        noise_gate_active,
                        low_voltage_supply_rail_active,
                        core_powered_up & ~core_shutdown_transient};

  // once shutdown is complete the slot stays silent
  assign tx_allowed = ctrl_reg[`FTR_CTRL_TX_BIT] & ~hw_sd &
                      (~shut | core_shutdown_transient);

  // pin synchronisers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sd_sync_reg   <= 2'b00;
      bclk_sync_reg <= 2'b00;
      fs_sync_reg   <= 2'b00;
      bclk_prev_reg <= 1'b0;
    end
    else
    begin
      sd_sync_reg   <= {sd_sync_reg[0], hw_shutdown_n};
      bclk_sync_reg <= {bclk_sync_reg[0], serial_bit_clock};
      fs_sync_reg   <= {fs_sync_reg[0], frame_sync};
      bclk_prev_reg <= bclk_sync_reg[1];
    end
  end

  // flags, masks and outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg                <= `FTR_CTRL_RESET;
      live_reg                <= {`FTR_LIVE_W{1'b0}};
      latched_reg             <= {`FTR_FLAG_W{1'b0}};
      mask_reg                <= `FTR_MASK_RESET;
      interrupt_request_n_out <= 1'b0;
      interrupt_request_n_oe  <= 1'b0;
      input_pulldown_enable   <= 5'h00;
      fault_shutdown          <= 1'b0;
    end
    else
    begin
      live_reg    <= live_next;
      latched_reg <= latched_next;
      if (wr_access && paddr == `FTR_OFS_CTRL)
      begin
        ctrl_reg <= pwdata & `FTR_CTRL_WMASK;
      end
      if (wr_access && paddr == `FTR_OFS_MASK)
      begin
        mask_reg <= pwdata[`FTR_FLAG_W-1:0];
      end
      // pll and regulator faults hold the device down until hardware shutdown
      if (hw_sd)
      begin
        fault_shutdown <= 1'b0;
      end
      else if (ev_pll_clock_error | ev_regulator_overvoltage |
               ev_regulator_undervoltage | ev_regulator_overload)
      begin
        fault_shutdown <= 1'b1;
      end
      // open drain: output low, enable while an unmasked flag stands
      interrupt_request_n_out <= 1'b0;
      interrupt_request_n_oe  <= |(latched_next & ~mask_reg);
      input_pulldown_enable   <= hw_sd ? 5'h00 :
                                 ctrl_reg[`FTR_CTRL_PD_MSB:`FTR_CTRL_PD_LSB];
    end
  end

  // apb answer: data captured in setup, always ready in access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata       <= 32'h0000_0000;
      pready       <= 1'b1;
      pslverr      <= 1'b0;
      rd_clear_reg <= {`FTR_FLAG_W{1'b0}};
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        pslverr      <= ~mapped(paddr);
        rd_clear_reg <= {`FTR_FLAG_W{1'b0}};
        prdata       <= 32'h0000_0000;
        if (!pwrite)
        begin
          case (paddr)
            `FTR_OFS_CTRL:
            begin
              prdata <= ctrl_reg;
            end
            `FTR_OFS_LIVE:
            begin
              prdata <= {{(32-`FTR_LIVE_W){1'b0}}, live_reg};
            end
            `FTR_OFS_LATCHED:
            begin
              prdata       <= {{(32-`FTR_FLAG_W){1'b0}}, latched_reg};
              rd_clear_reg <= latched_reg;
            end
            `FTR_OFS_MASK:
            begin
              prdata <= {{(32-`FTR_FLAG_W){1'b0}}, mask_reg};
            end
            `FTR_OFS_STATE:
            begin
              prdata <= {21'h000000, tx_allowed, hw_sd, fault_shutdown, status_word};
            end
            default:
            begin
              prdata <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end

  ftr_slot_tx
  #(
    .SLOT_BITS (SLOT_BITS),
    .WORD_BITS (`FTR_WORD_BITS)
  )
  u_slot_tx
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .bclk_rise   (bclk_rise),
    .bclk_fall   (bclk_fall),
    .fsync_level (fs_sync_reg[1]),
    .tx_enable   (tx_allowed),
    .slot_sel    (ctrl_reg[`FTR_CTRL_SLOT_MSB:`FTR_CTRL_SLOT_LSB]),
    .status_word (status_word),
    .sdata_out   (status_sdata_out),
    .sdata_oe    (status_sdata_oe)
  );

endmodule // ftr_fault_reporter

`default_nettype wire

// *** ftr_host_model.sv ***
// Purpose: host end of the status link, makes bit clock and frame sync
// Assumes: device changes data after a bit clock fall, host samples at rise
// Notes:   bit clock stands low between frames; a released line reads inverted
`include "ftr_map.vh"
`default_nettype none
module ftr_host_model
(
  // link pins
  output logic      serial_bit_clock,
  output logic      frame_sync,
  input  wire logic sdata_out,
  input  wire logic sdata_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic line_q = 1'b0;
  initial
  begin
    serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
  end
  // one frame; returns the word of the slot and the count of driven bits
  task automatic frame(input int nbits, input int slot, output logic [7:0] word,
                       output int driven);
    int k;
    driven = 0;
    word = 8'h00;
    frame_sync = 1'b1;
    #62.5 serial_bit_clock = 1'b1;
    #62.5 serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
    for (k = 0; k < nbits; k++)
    begin
      #62.5 serial_bit_clock = 1'b1;
      line_q = sdata_oe ? sdata_out : ~line_q;
      if (sdata_oe)
        driven++;
      if (k >= slot * `FTR_SLOT_BITS && k < slot * `FTR_SLOT_BITS + 8)
        word = {word[6:0], sdata_oe & line_q}; // undriven bits count as zero
      #62.5 serial_bit_clock = 1'b0;
    end
  endtask
endmodule // ftr_host_model
`default_nettype wire

// *** ftr_map.vh ***
// Purpose: register offsets, field positions and reset values of the fault reporter
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   latched and mask registers share one bit layout
`ifndef FTR_MAP_VH
`define FTR_MAP_VH

// register byte offsets
`define FTR_OFS_CTRL      12'h000
`define FTR_OFS_LIVE      12'h004
`define FTR_OFS_LATCHED   12'h008
`define FTR_OFS_MASK      12'h00c
`define FTR_OFS_STATE     12'h010

// control register fields
`define FTR_CTRL_TX_BIT   0
`define FTR_CTRL_SLOT_LSB 8
`define FTR_CTRL_SLOT_MSB 13
`define FTR_CTRL_PD_LSB   16
`define FTR_CTRL_PD_MSB   20
`define FTR_CTRL_RESET    32'h0000_0000
`define FTR_CTRL_WMASK    32'h001f_3f01

// latched and mask layout
`define FTR_B_BAD_RATIO   0
`define FTR_B_FRAME_CHG   1
`define FTR_B_RATIO_CHG   2
`define FTR_B_BELOW_INFL  3
`define FTR_B_LIM_ACTIVE  4
`define FTR_B_LIM_MAXATT  5
`define FTR_B_PLL_ERR     6
`define FTR_B_REG_OV      7
`define FTR_B_REG_UV      8
`define FTR_B_REG_OL      9
`define FTR_B_THERM_ONE   10
`define FTR_B_THERM_TWO   11
`define FTR_B_BROWNOUT_PD 12
`define FTR_B_DIAG_DONE   13
`define FTR_B_LOAD_OPEN   14
`define FTR_B_LOAD_SHORT  15
`define FTR_FLAG_W        16
`define FTR_MASK_RESET    16'hf2c7

// live register width
`define FTR_LIVE_W        5

// link framing
`define FTR_SLOT_BITS     32
`define FTR_WORD_BITS     8

`endif

// *** ftr_slot_tx.v ***
// Purpose: shift the status word into one slot of the serial output frame
// Assumes: bit clock edges arrive as one-cycle enables on pclk
// Notes:   one bit of delay after frame sync, msb first, pin released here outside the chosen slot
`include "ftr_map.vh"
`default_nettype none

module ftr_slot_tx
#(
  parameter SLOT_BITS = `FTR_SLOT_BITS,
  parameter WORD_BITS = `FTR_WORD_BITS
)
(
  // clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // link timing
  input  wire                 bclk_rise,
  input  wire                 bclk_fall,
  input  wire                 fsync_level,
  // slot selection
  input  wire                 tx_enable,
  input  wire [5:0]           slot_sel,
  input  wire [WORD_BITS-1:0] status_word,
  // serial output
  output reg                  sdata_out,
  output reg                  sdata_oe
);

  localparam CW = $clog2(SLOT_BITS);

  reg [CW-1:0]        bit_cnt_reg;
  reg [5:0]           slot_cnt_reg;
  reg                 fsync_prev_reg;
  reg                 framed_reg;
  reg [WORD_BITS-1:0] word_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_reg    <= {CW{1'b0}};
      slot_cnt_reg   <= 6'h00;
      fsync_prev_reg <= 1'b0;
      framed_reg     <= 1'b0;
      word_reg       <= {WORD_BITS{1'b0}};
      sdata_out      <= 1'b0;
      sdata_oe       <= 1'b0;
    end
    else
    begin
      // let go of the line at once when transmission is withdrawn between bit clocks
      if (!tx_enable)
      begin
        sdata_out <= 1'b0;
        sdata_oe  <= 1'b0;
      end
      if (bclk_rise)
      begin
        fsync_prev_reg <= fsync_level;
        if (fsync_level && !fsync_prev_reg)
        begin
          bit_cnt_reg  <= {CW{1'b0}};
          slot_cnt_reg <= 6'h00;
          framed_reg   <= 1'b1;
          word_reg     <= status_word;
        end
      end
      if (bclk_fall)
      begin
        // drive only the status bits of the chosen slot
        if (framed_reg && tx_enable && slot_cnt_reg == slot_sel &&
            bit_cnt_reg < WORD_BITS)
        begin
          sdata_out <= word_reg[WORD_BITS - 1 - bit_cnt_reg];
          sdata_oe  <= 1'b1;
        end
        else
        begin
          sdata_out <= 1'b0;
          sdata_oe  <= 1'b0;
        end
        if (bit_cnt_reg == SLOT_BITS - 1)
        begin
          bit_cnt_reg  <= {CW{1'b0}};
          slot_cnt_reg <= slot_cnt_reg + 6'h01;
        end
        else
        begin
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule // ftr_slot_tx

`default_nettype wire

// *** tb_fault_flag_and_tdm_status_reporter.sv ***
// Purpose: self-checking bench of the fault reporter
// Assumes: apb master here, host model on the status link
// Notes:   fault events run late since they hold the output stage down
`include "ftr_map.vh"
`default_nettype none
module tb_fault_flag_and_tdm_status_reporter;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [10:0] ev = 11'h000;
  logic [4:0]  cond = 5'h00;
  logic [10:0] st = 11'h000;
  logic        hw_sd_n = 1'b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, bclk, fsync, sd_out, sd_oe, irq_out, irq_oe, fault_sd;
  wire  [4:0]  pd_en;
  wire         irq_pin = irq_oe ? 1'b0 : 1'b1;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  word;
  int          driven;
  int          lbit [11] = '{0, 1, 2, 6, 7, 8, 9, 12, 13, 14, 15};

  always #5 pclk = ~pclk;

  ftr_fault_reporter ftr_fault_reporter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ev_bad_ratio_or_rate(ev[0]),
    .ev_frame_rate_changed(ev[1]), .ev_clock_ratio_changed(ev[2]), .ev_pll_clock_error(ev[3]),
    .ev_regulator_overvoltage(ev[4]), .ev_regulator_undervoltage(ev[5]),
    .ev_regulator_overload(ev[6]), .ev_brownout_powerdown(ev[7]),
    .ev_load_diag_complete(ev[8]), .ev_load_open(ev[9]), .ev_load_short(ev[10]),
    .cond_supply_below_inflection(cond[0]), .cond_limiter_active(cond[1]),
    .cond_limiter_max_attenuation(cond[2]), .cond_thermal_threshold_one(cond[3]),
    .cond_thermal_threshold_two(cond[4]), .core_powered_up(st[0]), .core_sw_shutdown(st[1]),
    .core_shutdown_transient(st[2]), .low_voltage_supply_rail_active(st[3]),
    .noise_gate_active(st[4]), .limiter_attenuating(st[5]),
    .inter_chip_limiter_alignment_attenuating(st[6]), .brownout_prevention_attenuating(st[7]),
    .over_temperature(st[8]), .over_current(st[9]), .power_stage_supply_undervoltage(st[10]),
    .hw_shutdown_n(hw_sd_n), .serial_bit_clock(bclk), .frame_sync(fsync),
    .status_sdata_out(sd_out), .status_sdata_oe(sd_oe), .interrupt_request_n_out(irq_out),
    .interrupt_request_n_oe(irq_oe), .input_pulldown_enable(pd_en), .fault_shutdown(fault_sd));

  ftr_host_model host_model_inst (.serial_bit_clock(bclk), .frame_sync(fsync),
    .sdata_out(sd_out), .sdata_oe(sd_oe));

  task automatic finish_test;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      miscompares++;
      finish_test();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pulse(input int n);
    @(posedge pclk);
    ev[n] <= 1'b1;
    @(posedge pclk);
    ev[n] <= 1'b0;
    settle();
  endtask

  task automatic t_regs;
    rchk(`FTR_OFS_CTRL, 32'h0);
    rchk(`FTR_OFS_MASK, 32'h0000_f2c7);
    apb(1'b1, `FTR_OFS_LIVE, 32'h1f);
    rchk(`FTR_OFS_LIVE, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_frame(input logic [31:0] ctrl, input int slot, input logic [7:0] exp);
    apb(1'b1, `FTR_OFS_CTRL, ctrl);
    host_model_inst.frame(4 * `FTR_SLOT_BITS, slot, word, driven);
    @(posedge pclk);
    chk(driven, ctrl[0] ? 32'h8 : 32'h0);
    chk({24'h0, word}, {24'h0, exp});
  endtask

  task automatic t_status;
    st <= 11'h351;
    t_frame(32'h0201, 2, 8'h0d);
    st <= 11'h0a9;
    t_frame(32'h0301, 3, 8'h1b);
    st <= 11'h504;
    t_frame(32'h0001, 0, 8'ha0);
    t_frame(32'h0000, 0, 8'h00);
    st <= 11'h001;
  endtask

  task automatic t_live;
    cond <= 5'h1f;
    settle();
    rchk(`FTR_OFS_LIVE, 32'h1f);
    st[1] <= 1'b1;
    settle();
    chk({31'h0, irq_pin}, 32'h0);
    rchk(`FTR_OFS_LIVE, 32'h0);
    cond <= 5'h00;
    st[1] <= 1'b0;
    settle();
    rchk(`FTR_OFS_LATCHED, 32'h0c38);
    rchk(`FTR_OFS_LATCHED, 32'h0);
    settle();
    chk({31'h0, irq_pin}, 32'h1);
  endtask

  task automatic t_fault;
    int i;
    for (i = 0; i < 11; i++)
    begin
      pulse(i);
      chk({31'h0, irq_pin}, {31'h0, lbit[i] != 8});
      rchk(`FTR_OFS_LATCHED, 32'h1 << lbit[i]);
      settle();
      chk({31'h0, irq_pin}, 32'h1);
    end
    chk({31'h0, fault_sd}, 32'h1);
    apb(1'b1, `FTR_OFS_MASK, 32'h0);
    pulse(3);
    chk({31'h0, irq_pin}, 32'h0);
    apb(1'b1, `FTR_OFS_LATCHED, 32'h40);
    settle();
    chk({31'h0, irq_pin}, 32'h1);
    @(posedge pclk);
    cond <= 5'h1f;
    settle();
    rchk(`FTR_OFS_LIVE, 32'h0);
    cond <= 5'h00;
  endtask

  task automatic t_pd;
    apb(1'b1, `FTR_OFS_CTRL, 32'h0015_0000);
    settle();
    chk({27'h0, pd_en}, 32'h15);
    @(posedge pclk);
    hw_sd_n <= 1'b0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk({27'h0, pd_en}, 32'h0);
    chk({31'h0, fault_sd}, 32'h0);
    @(posedge pclk);
    hw_sd_n <= 1'b1;
    settle();
  endtask

  initial
  begin
    #200_000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_status();
    t_live();
    t_fault();
    t_pd();
    finish_test();
  end
endmodule // tb_fault_flag_and_tdm_status_reporter
`default_nettype wire
